/* core/rft_down_counter.sv */
// 16-bit reloadable down counter shared by timer2 and timer3
`timescale 1ns/100ps
`default_nettype none
module rft_down_counter
    import rft_pkg::*;
(
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire rft_cnt_cmd_s cmd_in,
    output logic [15:0]       count_out,
    output logic              running_out,
    output logic              underflow_out
);
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic        running_r;
    logic        running_nxt;
    logic        underflow_r;
    logic        at_zero;
    logic        step;

    assign at_zero = (count_r == 16'h0000);
    assign step    = running_r && cmd_in.tick && !cmd_in.load && !cmd_in.halt;

    // load beats halt; an underflow is a decrement from zero
    always_comb begin
        count_nxt   = count_r;
        running_nxt = running_r;
        if (cmd_in.load) begin
            count_nxt   = cmd_in.reload;
            running_nxt = 1'b1;
        end else if (cmd_in.halt) begin
            running_nxt = 1'b0;
        end else if (step && at_zero) begin
            if (cmd_in.auto_reload) begin
                count_nxt = cmd_in.reload;
            end else begin
                running_nxt = 1'b0;
            end
        end else if (step) begin
            count_nxt = count_r - 16'h0001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            count_r     <= RST_COUNT;
            running_r   <= 1'b0;
            underflow_r <= 1'b0;
        end else begin
            count_r     <= count_nxt;
            running_r   <= running_nxt;
            underflow_r <= step && at_zero;
        end
    end

    assign count_out     = count_r;
    assign running_out   = running_r;
    assign underflow_out = underflow_r;

endmodule : rft_down_counter
`default_nettype wire

/* core/rft_pkg.sv */
// shared constants, types and register map of the rf frontend timer block
package rft_pkg;

    // register byte addresses on the host register port
    localparam logic [7:0] ADDR_T2_RELOAD_LO = 8'h1b;
    localparam logic [7:0] ADDR_T2_COUNT_HI  = 8'h1c;
    localparam logic [7:0] ADDR_T2_COUNT_LO  = 8'h1d;
    localparam logic [7:0] ADDR_T3_CONTROL   = 8'h1e;
    localparam logic [7:0] ADDR_T3_RELOAD_HI = 8'h1f;
    localparam logic [7:0] ADDR_T3_RELOAD_LO = 8'h20;
    localparam logic [7:0] ADDR_T3_COUNT_HI  = 8'h21;
    localparam logic [7:0] ADDR_T3_COUNT_LO  = 8'h22;

    // values after reset
    localparam logic [7:0]  RST_T3_CONTROL = 8'h00;
    localparam logic [7:0]  RST_RELOAD     = 8'h00;
    localparam logic [15:0] RST_COUNT      = 16'h0000;
    localparam logic [7:0]  RDATA_UNMAPPED = 8'h00;

    // field positions inside timer3_control
    localparam int CTRL_HALT_BIT  = 7;
    localparam int CTRL_AUTO_BIT  = 3;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'hbb; // bits 6 and 2 reserved

    // base clock and the slow clock derived from it
    localparam int SYS_TICK_HZ  = 13_560_000;
    localparam int SLOW_TICK_HZ = 211_875;
    localparam int SLOW_DIV     = SYS_TICK_HZ / SLOW_TICK_HZ;
    localparam logic [5:0] SLOW_DIV_LAST = 6'(SLOW_DIV - 1);

    // automatic start selection
    typedef enum logic [1:0] {
        START_NONE   = 2'b00,
        START_TX_END = 2'b01,
        START_TRIM   = 2'b10,
        START_TRIM_UF = 2'b11
    } rft_start_e;

    // counter input clock selection
    typedef enum logic [1:0] {
        CLK_SYS  = 2'b00,
        CLK_SLOW = 2'b01,
        CLK_T0UF = 2'b10,
        CLK_T1UF = 2'b11
    } rft_clk_e;

    // timer3_control layout
    typedef struct packed {
        logic       halt_on_receive;
        logic       reserved_bit_6;
        rft_start_e start_mode_select;
        logic       auto_reload_enable;
        logic       reserved_bit_2;
        rft_clk_e   input_clock_select;
    } rft_ctrl_s;

    // counter command bundle
    typedef struct packed {
        logic        load;
        logic        halt;
        logic        tick;
        logic        auto_reload;
        logic [15:0] reload;
    } rft_cnt_cmd_s;

endpackage : rft_pkg

/* core/rft_tick_select.sv */
// input clock selection and divide-by-64 slow tick for the timer
`timescale 1ns/100ps
`default_nettype none
module rft_tick_select
    import rft_pkg::*;
(
    input  wire logic     clk_in,
    input  wire logic     rst_in,
    input  wire logic     sys_tick_in,
    input  wire logic     t0_underflow_in,
    input  wire logic     t1_underflow_in,
    input  wire rft_clk_e sel_in,
    output logic          tick_out
);
    logic [5:0] div_r;
    logic [5:0] div_nxt;
    logic       slow_tick;

    // divider advances only on base ticks so the slow tick is exactly 1/64 of them
    assign slow_tick = sys_tick_in && (div_r == SLOW_DIV_LAST);
    assign div_nxt   = sys_tick_in ? div_r + 6'h01 : div_r;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            div_r <= 6'h00;
        end else begin
            div_r <= div_nxt;
        end
    end

    // one decrement strobe per event of the chosen source
    always_comb begin
        unique case (sel_in)
            CLK_SYS:  tick_out = sys_tick_in;
            CLK_SLOW: tick_out = slow_tick;
            CLK_T0UF: tick_out = t0_underflow_in;
            CLK_T1UF: tick_out = t1_underflow_in;
        endcase
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    slow_tick_rate_a: assert property ((sel_in == CLK_SLOW && tick_out) |->
        sys_tick_in && div_r == 6'h3f)
        else $error("slow tick not on 64th base tick");
    cascade_tick_a: assert property ((sel_in == CLK_T1UF) |->
        (tick_out == t1_underflow_in))
        else $error("cascade tick does not follow timer1 underflow");

endmodule : rft_tick_select
`default_nettype wire

/* core/rft_timer_unit.sv */
// timer3 with its control, reload and readback registers, plus timer2 reload-low and readback
// What this block does
// - halt-on-receive set: timer3 halts when the first four received bits arrive
// - halt-on-receive is ignored while start mode selects oscillator trimming
// - start mode 00 never starts automatically; 01 starts at transmit end
// - modes 10 and 11 trim the oscillator, start/stop on rising edges, 11 underflows
// - auto reload set outside start mode 10: reload the 16-bit value and keep counting at zero
// - auto reload clear: count to zero, stop and hold zero
// - timer3 underflow outside start mode 10 raises the timer interrupt request flag
// - clock select 00 uses 13.56 MHz, 01 uses that divided by 64
// - clock select 10 and 11 count timer0 or timer1 underflows
// - each start loads timer3 from its high and low reload bytes
// - reload writes never disturb a running count; used at next start
// - each timer2 start loads from its reload bytes, low byte bits 7..0
// - live timer3 count readable as read-only high and low bytes
// - live timer2 count readable as read-only high and low bytes
`timescale 1ns/100ps
`default_nettype none
module rft_timer_unit
    import rft_pkg::*;
(
    input  wire logic        CLK_IN,
    input  wire logic        RST_IN,
    // host register port
    input  wire logic [7:0]  ADDR_IN,
    input  wire logic [7:0]  WDATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    output logic [7:0]       RDATA_OUT,
    // events from the rest of the frontend
    input  wire logic        SYS_TICK_IN,
    input  wire logic        TX_END_IN,
    input  wire logic        RX_FIRST4_IN,
    input  wire logic        OSC_EDGE_IN,
    input  wire logic        T0_UNDERFLOW_IN,
    input  wire logic        T1_UNDERFLOW_IN,
    input  wire logic        T3_START_NOW_IN,
    input  wire logic        T3_STOP_NOW_IN,
    // timer2 side: control lives in the neighbouring timer logic
    input  wire logic [7:0]  T2_RELOAD_HI_IN,
    input  wire logic        T2_START_IN,
    input  wire logic        T2_STOP_IN,
    input  wire logic        T2_TICK_IN,
    input  wire logic        T2_AUTO_RELOAD_IN,
    output logic             T2_UNDERFLOW_OUT,
    // timer3 status towards the interrupt and trimming logic
    output logic             T3_RUNNING_OUT,
    output logic             T3_UNDERFLOW_OUT,
    output logic             TIMER_IRQ_SET_OUT
);
    // ---- register file state
    rft_ctrl_s   ctrl_r;
    logic [7:0]  t3_reload_hi_r;
    logic [7:0]  t3_reload_lo_r;
    logic [7:0]  t2_reload_lo_r;
    logic [7:0]  rdata_r;
    logic [7:0]  rdata_nxt;
    logic        irq_r;

    // ---- timer3 control decode
    logic        trim_mode;
    logic        trim_wrap;
    logic        t3_tick;
    logic        t3_load;
    logic        t3_halt;
    logic        rx_halt;
    logic        trim_start;
    logic        trim_stop;
    logic [15:0] reload_value_16;
    logic [15:0] t3_count;
    logic        t3_running;
    logic        t3_underflow;
    rft_cnt_cmd_s t3_cmd;

    // ---- timer2
    logic [15:0] t2_count;
    logic        t2_running;
    rft_cnt_cmd_s t2_cmd;

    // ---- write strobes
    logic        wr_ctrl;
    logic        wr_t3_hi;
    logic        wr_t3_lo;
    logic        wr_t2_lo;

    // address match, used by the write decode
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction : hit

    // write decode
    assign wr_ctrl  = WR_IN && hit(ADDR_IN, ADDR_T3_CONTROL);
    assign wr_t3_hi = WR_IN && hit(ADDR_IN, ADDR_T3_RELOAD_HI);
    assign wr_t3_lo = WR_IN && hit(ADDR_IN, ADDR_T3_RELOAD_LO);
    assign wr_t2_lo = WR_IN && hit(ADDR_IN, ADDR_T2_RELOAD_LO);

    // control register: reserved bits are masked on write so they always read zero
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            ctrl_r <= rft_ctrl_s'(RST_T3_CONTROL);
        end else if (wr_ctrl) begin
            ctrl_r <= rft_ctrl_s'(WDATA_IN & CTRL_WRITE_MASK);
        end
    end

    // reload bytes are only copied into the counter on a start event or an auto reload at zero
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            t3_reload_hi_r <= RST_RELOAD;
            t3_reload_lo_r <= RST_RELOAD;
            t2_reload_lo_r <= RST_RELOAD;
        end else begin
            if (wr_t3_hi) begin
                t3_reload_hi_r <= WDATA_IN;
            end
            if (wr_t3_lo) begin
                t3_reload_lo_r <= WDATA_IN;
            end
            if (wr_t2_lo) begin
                t2_reload_lo_r <= WDATA_IN;
            end
        end
    end

    // start and stop sources for timer3
    assign trim_mode       = ctrl_r.start_mode_select[1];
    assign trim_wrap       = (ctrl_r.start_mode_select == START_TRIM_UF);
    assign trim_start      = trim_mode && OSC_EDGE_IN && !t3_running;
    assign trim_stop       = trim_mode && OSC_EDGE_IN && t3_running;
    assign rx_halt         = ctrl_r.halt_on_receive && !trim_mode
                             && RX_FIRST4_IN;
    assign t3_load         = T3_START_NOW_IN || trim_start
                             || (ctrl_r.start_mode_select == START_TX_END
                                 && TX_END_IN);
    assign t3_halt         = T3_STOP_NOW_IN || trim_stop || rx_halt;
    assign reload_value_16 = {t3_reload_hi_r, t3_reload_lo_r};

    // trimming without underflow never wraps, it simply ends at zero
    assign t3_cmd.load        = t3_load;
    assign t3_cmd.halt        = t3_halt;
    assign t3_cmd.tick        = t3_tick;
    assign t3_cmd.auto_reload = ctrl_r.auto_reload_enable
                                && (!trim_mode || trim_wrap);
    assign t3_cmd.reload      = reload_value_16;

    rft_tick_select u_t3_tick (
        .clk_in          (CLK_IN),
        .rst_in          (RST_IN),
        .sys_tick_in     (SYS_TICK_IN),
        .t0_underflow_in (T0_UNDERFLOW_IN),
        .t1_underflow_in (T1_UNDERFLOW_IN),
        .sel_in          (ctrl_r.input_clock_select),
        .tick_out        (t3_tick)
    );

    rft_down_counter u_t3_counter (
        .clk_in        (CLK_IN),
        .rst_in        (RST_IN),
        .cmd_in        (t3_cmd),
        .count_out     (t3_count),
        .running_out   (t3_running),
        .underflow_out (t3_underflow)
    );

    // timer2 counter: its start, stop and tick come from its own control logic
    assign t2_cmd.load        = T2_START_IN;
    assign t2_cmd.halt        = T2_STOP_IN;
    assign t2_cmd.tick        = T2_TICK_IN;
    assign t2_cmd.auto_reload = T2_AUTO_RELOAD_IN;
    assign t2_cmd.reload      = {T2_RELOAD_HI_IN, t2_reload_lo_r};

    rft_down_counter u_t2_counter (
        .clk_in        (CLK_IN),
        .rst_in        (RST_IN),
        .cmd_in        (t2_cmd),
        .count_out     (t2_count),
        .running_out   (t2_running),
        .underflow_out (T2_UNDERFLOW_OUT)
    );

    // interrupt request: trimming without underflow raises nothing
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= t3_underflow && !(trim_mode && !trim_wrap);
        end
    end

    // read mux; counts are sampled live, so a read during reception may tear
    always_comb begin
        unique case (ADDR_IN)
            ADDR_T2_RELOAD_LO: rdata_nxt = t2_reload_lo_r;
            ADDR_T2_COUNT_HI:  rdata_nxt = t2_count[15:8];
            ADDR_T2_COUNT_LO:  rdata_nxt = t2_count[7:0];
            ADDR_T3_CONTROL:   rdata_nxt = ctrl_r;
            ADDR_T3_RELOAD_HI: rdata_nxt = t3_reload_hi_r;
            ADDR_T3_RELOAD_LO: rdata_nxt = t3_reload_lo_r;
            ADDR_T3_COUNT_HI:  rdata_nxt = t3_count[15:8];
            ADDR_T3_COUNT_LO:  rdata_nxt = t3_count[7:0];
            default:           rdata_nxt = RDATA_UNMAPPED;
        endcase
    end

    // read data is held until the next read strobe
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            rdata_r <= RDATA_UNMAPPED;
        end else if (RD_IN) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign RDATA_OUT         = rdata_r;
    assign T3_RUNNING_OUT    = t3_running;
    assign T3_UNDERFLOW_OUT  = t3_underflow;
    assign TIMER_IRQ_SET_OUT = irq_r;

    // ---------------------------------------------------------------- checks
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    // a plain decrement with no competing command
    sequence s_plain_step;
        t3_running && t3_tick && !t3_load && !t3_halt && t3_count != 16'h0000;
    endsequence

    // counting reaches zero and the next tick decrements from it
    sequence s_zero_step;
        t3_running && t3_tick && !t3_load && !t3_halt && t3_count == 16'h0000;
    endsequence

    rx_halt_stop_a: assert property ((ctrl_r.halt_on_receive && !trim_mode
        && RX_FIRST4_IN && t3_running && !t3_load) |=> !t3_running)
        else $error("reception did not halt timer3");
    rx_trim_ignore_a: assert property ((trim_mode && RX_FIRST4_IN && t3_running
        && !OSC_EDGE_IN && !T3_STOP_NOW_IN
        && !(t3_tick && t3_count == 16'h0000)) |=> t3_running)
        else $error("reception halted timer3 in trimming mode");
    tx_end_start_a: assert property ((ctrl_r.start_mode_select == START_TX_END
        && TX_END_IN) |=> t3_running && t3_count == $past(reload_value_16))
        else $error("transmit end did not start timer3");
    no_auto_start_a: assert property ((ctrl_r.start_mode_select == START_NONE
        && !T3_START_NOW_IN) |-> !t3_load)
        else $error("timer3 started without a start request");
    trim_edge_start_a: assert property ((trim_mode && OSC_EDGE_IN && !t3_running
        && !T3_STOP_NOW_IN) |=> t3_running ##1 (t3_running || OSC_EDGE_IN
        || T3_STOP_NOW_IN || $past(t3_underflow) || t3_underflow || $past(t3_halt)))
        else $error("oscillator edge did not start trimming");
    wrap_reload_a: assert property ((s_zero_step and ##0 t3_cmd.auto_reload)
        |=> t3_running && t3_count == $past(reload_value_16))
        else $error("auto reload did not restart from reload value");
    zero_hold_a: assert property ((s_zero_step and ##0 !t3_cmd.auto_reload)
        |=> !t3_running && t3_count == 16'h0000 ##1 (t3_count == 16'h0000 || $past(t3_load)))
        else $error("timer3 did not stop and hold zero");
    irq_raise_a: assert property ((s_zero_step and ##0 (!trim_mode || trim_wrap))
        |=> t3_underflow ##1 TIMER_IRQ_SET_OUT)
        else $error("underflow did not raise the interrupt request");
    reload_load_a: assert property (t3_load |=> t3_count == $past(reload_value_16))
        else $error("start did not load the reload value");
    reload_quiet_a: assert property (((wr_t3_hi || wr_t3_lo) && !t3_load
        && !(t3_running && t3_tick)) |=> t3_count == $past(t3_count))
        else $error("reload write disturbed the count");
    t2_load_a: assert property (T2_START_IN |=>
        t2_count == {$past(T2_RELOAD_HI_IN), $past(t2_reload_lo_r)})
        else $error("timer2 start did not load its reload bytes");
    t3_readback_a: assert property ((RD_IN && ADDR_IN == ADDR_T3_COUNT_LO)
        |=> RDATA_OUT == $past(t3_count[7:0]))
        else $error("timer3 low count byte read back wrong");
    t2_readback_a: assert property ((RD_IN && ADDR_IN == ADDR_T2_COUNT_HI)
        |=> RDATA_OUT == $past(t2_count[15:8]))
        else $error("timer2 high count byte read back wrong");
    reserved_zero_a: assert property (ctrl_r.reserved_bit_6 == 1'b0
        && ctrl_r.reserved_bit_2 == 1'b0)
        else $error("reserved control bits not zero");
    step_by_one_a: assert property (s_plain_step |=>
        t3_count == $past(t3_count) - 16'h0001)
        else $error("timer3 did not decrement by one");
    idle_still_a: assert property ((!t3_running && !t3_load) |=>
        t3_count == $past(t3_count))
        else $error("stopped timer3 changed its count");

endmodule : rft_timer_unit
`default_nettype wire

/* verif/rft_timer_unit_tb.sv */
// self-checking testbench for the rf frontend timer unit
`timescale 1ns/100ps
`default_nettype none
module rft_timer_unit_tb
    import rft_pkg::*;
;
    // event pulse lanes into the unit
    localparam int E_SYS = 0, E_TX = 1, E_RX = 2, E_OSC = 3, E_T0 = 4, E_T1 = 5;
    localparam int E_GO = 6, E_STOP = 7, E_T2S = 8, E_T2P = 9, E_T2T = 10;

    logic        clk, rst, wr_en, rd_en, rd_pend, t2_auto;
    logic [7:0]  addr, wdata, rdata, t2_hi, lo;
    logic [10:0] ev;
    logic [15:0] rv;
    logic        t2_uf, t3_run, t3_uf, irq;
    logic [7:0]  exp_q [$];
    logic [7:0]  amap [9] = '{ADDR_T2_RELOAD_LO, ADDR_T2_COUNT_HI, ADDR_T2_COUNT_LO,
        ADDR_T3_CONTROL, ADDR_T3_RELOAD_HI, ADDR_T3_RELOAD_LO, ADDR_T3_COUNT_HI,
        ADDR_T3_COUNT_LO, 8'h23};
    int          dec [4] = '{64, 1, 1, 1};
    int          seed, err_count, checks, n, s;

    rft_timer_unit dut_u (
        .CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr_en),
        .RD_IN(rd_en), .RDATA_OUT(rdata), .SYS_TICK_IN(ev[E_SYS]), .TX_END_IN(ev[E_TX]),
        .RX_FIRST4_IN(ev[E_RX]), .OSC_EDGE_IN(ev[E_OSC]), .T0_UNDERFLOW_IN(ev[E_T0]),
        .T1_UNDERFLOW_IN(ev[E_T1]), .T3_START_NOW_IN(ev[E_GO]), .T3_STOP_NOW_IN(ev[E_STOP]),
        .T2_RELOAD_HI_IN(t2_hi), .T2_START_IN(ev[E_T2S]), .T2_STOP_IN(ev[E_T2P]),
        .T2_TICK_IN(ev[E_T2T]), .T2_AUTO_RELOAD_IN(t2_auto), .T2_UNDERFLOW_OUT(t2_uf),
        .T3_RUNNING_OUT(t3_run), .T3_UNDERFLOW_OUT(t3_uf), .TIMER_IRQ_SET_OUT(irq)
    );

    // free running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task print_verdict;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict

    // read data shows one cycle after the strobe; compare it against the oldest note
    always @(posedge clk) rd_pend <= rd_en;
    always @(negedge clk) begin
        if (rd_pend && exp_q.size() > 0) check("rdata", rdata, exp_q.pop_front());
    end

    task reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : reg_wr

    task reg_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd_en <= 1'b0;
    endtask : reg_rd

    // counts are only read with no frame being received, since they may tear
    task rd16(input logic [7:0] a, input logic [15:0] e);
        reg_rd(a, e[15:8]);
        reg_rd(a + 8'h01, e[7:0]);
    endtask : rd16

    task pulse(input int i, input int cnt);
        for (int j = 0; j < cnt; j++) begin
            @(posedge clk) ev[i] <= 1'b1;
            @(posedge clk) ev[i] <= 1'b0;
        end
    endtask : pulse

    task arm(input logic [15:0] rl, input logic [7:0] c, input int e);
        reg_wr(ADDR_T3_RELOAD_HI, rl[15:8]);
        reg_wr(ADDR_T3_RELOAD_LO, rl[7:0]);
        reg_wr(ADDR_T3_CONTROL, c);
        pulse(e, 1);
    endtask : arm

    task chk_run(input logic e);
        @(negedge clk);
        check("t3_running", {7'h00, t3_run}, {7'h00, e});
    endtask : chk_run

    // wait a bounded time for the underflow pulse, then look at the irq pulse
    task uf_expect(input logic e);
        int k;
        @(negedge clk);
        for (k = 0; k < 8; k++) if (t3_uf !== 1'b1) @(negedge clk);
        check("t3_underflow", {7'h00, t3_uf}, 8'h01);
        @(negedge clk);
        check("irq_set", {7'h00, irq}, {7'h00, e});
    endtask : uf_expect

    task done(input string nm);
        $display("test %s finished", nm);
    endtask : done

    // watchdog sized well above the expected run of roughly a thousand cycles
    initial begin
        #(20000 * 4);
        err_count++;
        print_verdict();
    end

    initial begin
        seed = 6;
        {addr, wdata, wr_en, rd_en, t2_auto, t2_hi, ev} = '0;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        foreach (amap[i]) reg_rd(amap[i], 8'h00);
        reg_wr(ADDR_T3_CONTROL, 8'hff);
        reg_rd(ADDR_T3_CONTROL, 8'hbb);
        done("reset_and_control");
        // load, count down by random ticks, reload writes must not disturb
        rv = 16'($random(seed)) | 16'h0100;
        n  = 1 + ($random(seed) & 7);
        arm(rv, 8'h00, E_GO);
        rd16(ADDR_T3_RELOAD_HI, rv);
        rd16(ADDR_T3_COUNT_HI, rv);
        pulse(E_SYS, n);
        rd16(ADDR_T3_COUNT_HI, rv - 16'(n));
        reg_wr(ADDR_T3_RELOAD_HI, 8'h00);
        reg_wr(ADDR_T3_RELOAD_LO, 8'h00);
        rd16(ADDR_T3_COUNT_HI, rv - 16'(n));
        chk_run(1'b1);
        pulse(E_STOP, 1);
        done("load_count");
        // one shot stops at zero, auto reload wraps
        arm(16'h0002, 8'h00, E_GO);
        pulse(E_SYS, 3);
        uf_expect(1'b1);
        rd16(ADDR_T3_COUNT_HI, 16'h0000);
        chk_run(1'b0);
        arm(16'h0002, 8'h08, E_GO);
        pulse(E_SYS, 3);
        uf_expect(1'b1);
        rd16(ADDR_T3_COUNT_HI, 16'h0002);
        chk_run(1'b1);
        pulse(E_STOP, 1);
        done("underflow");
        // every input clock choice against every source
        for (s = 0; s < 4; s++) begin
            arm(16'h0100, 8'(s), E_GO);
            pulse(E_SYS, 64);
            pulse(E_T0, 1);
            pulse(E_T1, 1);
            rd16(ADDR_T3_COUNT_HI, 16'h0100 - 16'(dec[s]));
            pulse(E_STOP, 1);
        end
        done("clock_select");
        // halt on receive only outside trimming
        arm(16'h0100, 8'h80, E_GO);
        pulse(E_RX, 1);
        chk_run(1'b0);
        pulse(E_SYS, 1);
        rd16(ADDR_T3_COUNT_HI, 16'h0100);
        arm(16'h0100, 8'h00, E_GO);
        pulse(E_RX, 1);
        chk_run(1'b1);
        pulse(E_STOP, 1);
        arm(16'h0100, 8'ha0, E_OSC);
        chk_run(1'b1);
        pulse(E_RX, 1);
        chk_run(1'b1);
        pulse(E_OSC, 1);
        chk_run(1'b0);
        done("halt_on_receive");
        // start modes: transmit end, none, trimming with and without wrap
        arm(16'h0100, 8'h10, E_TX);
        chk_run(1'b1);
        pulse(E_STOP, 1);
        arm(16'h0100, 8'h00, E_TX);
        chk_run(1'b0);
        arm(16'h0001, 8'h28, E_OSC);
        pulse(E_SYS, 2);
        repeat (4) begin
            @(negedge clk);
            check("irq_set", {7'h00, irq}, 8'h00);
        end
        rd16(ADDR_T3_COUNT_HI, 16'h0000);
        arm(16'h0001, 8'h38, E_OSC);
        pulse(E_SYS, 2);
        uf_expect(1'b1);
        rd16(ADDR_T3_COUNT_HI, 16'h0001);
        pulse(E_OSC, 1);
        done("start_modes");
        // timer2 load from both reload bytes and live readback
        lo = 8'($random(seed));
        @(posedge clk) t2_hi <= 8'($random(seed)) | 8'h01;
        reg_wr(ADDR_T2_RELOAD_LO, lo);
        reg_rd(ADDR_T2_RELOAD_LO, lo);
        pulse(E_T2S, 1);
        rd16(ADDR_T2_COUNT_HI, {t2_hi, lo});
        pulse(E_T2T, 1);
        rd16(ADDR_T2_COUNT_HI, {t2_hi, lo} - 16'h0001);
        pulse(E_T2P, 1);
        // a zero reload underflows on the first tick after the start
        @(posedge clk) t2_hi <= 8'h00;
        reg_wr(ADDR_T2_RELOAD_LO, 8'h00);
        pulse(E_T2S, 1);
        pulse(E_T2T, 1);
        @(negedge clk);
        check("t2_underflow", {7'h00, t2_uf}, 8'h01);
        pulse(E_T2P, 1);
        done("timer2");
        repeat (4) @(posedge clk);
        print_verdict();
    end

endmodule : rft_timer_unit_tb
`default_nettype wire
